/* fmsl_pkg.sv */
// Shared constants and types for the front-panel lamp driver.
package fmsl_pkg;
    // Clock rate and the one-second time base.
    localparam int unsigned FMSL_CLK_HZ = 50000000;
    localparam int unsigned FMSL_TICK_MS = 1000;
    localparam int unsigned FMSL_TICK_CYC = FMSL_CLK_HZ / 1000 * FMSL_TICK_MS;
    // Length of one brief flash or blink, in milliseconds and cycles.
    localparam int unsigned FMSL_FLASH_MS = 100;
    localparam int unsigned FMSL_FLASH_CYC = FMSL_CLK_HZ / 1000 * FMSL_FLASH_MS;
    // Reset button debounce time and cycles.
    localparam int unsigned FMSL_DEB_MS = 20;
    localparam int unsigned FMSL_DEB_CYC = FMSL_CLK_HZ / 1000 * FMSL_DEB_MS;
    // Lamp layout: three channels, each a flame-on and a flame-signal lamp.
    localparam int unsigned FMSL_NCH = 3;
    localparam int unsigned FMSL_NLAMP = 7;
    localparam int unsigned FMSL_STR_W = 12;
    // Flash period of the flame-signal lamp: slowest and shortest, in ms.
    localparam int unsigned FMSL_SIG_SLOW_MS = 4000;
    localparam int unsigned FMSL_SIG_FAST_MS = 125;
    localparam int unsigned FMSL_SIG_STEPS = 6;
    // Register map of the AXI4-Lite slave (byte addresses).
    localparam logic [7:0] FMSL_ADDR_CTRL = 8'h00;
    localparam logic [7:0] FMSL_ADDR_STAT = 8'h04;
    localparam logic [7:0] FMSL_ADDR_LAMP = 8'h08;
    // Control field positions and reset value.
    localparam int unsigned FMSL_CTRL_ENA = 0;
    localparam int unsigned FMSL_CTRL_FORCE_LK = 1;
    localparam logic [31:0] FMSL_CTRL_RST = 32'h00000001;
    // Status field positions.
    localparam int unsigned FMSL_STAT_LK = 0;
    localparam int unsigned FMSL_STAT_MODE = 4;
    // Colour encoding of a two-element (red, green) lamp.
    localparam logic [1:0] FMSL_COL_OFF = 2'h0;
    localparam logic [1:0] FMSL_COL_RED = 2'h2;
    localparam logic [1:0] FMSL_COL_GRN = 2'h1;
    localparam logic [1:0] FMSL_COL_ORG = 2'h3;
    // AXI responses.
    localparam logic [1:0] FMSL_RESP_OK = 2'h0;
    localparam logic [1:0] FMSL_RESP_SLVERR = 2'h2;
    // Status heartbeat modes.
    typedef enum logic [2:0] {
        FMSL_HB_FAIL, FMSL_HB_NORMAL, FMSL_HB_HOT, FMSL_HB_COMM, FMSL_HB_LOCK
    } fmsl_hb_e;
endpackage

/* fmsl_sync.sv */
// Two-flop synchroniser with debounce for the reset button.
`timescale 1ns/10ps
module fmsl_sync
    import fmsl_pkg::*;
#(
    parameter int unsigned DEB_CYC = FMSL_DEB_CYC
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level,
    output logic press
);
    logic s1_reg, s2_reg, lvl_reg, prs_reg;
    logic lvl_next, prs_next;
    logic [20:0] cnt_reg, cnt_next;

    // Debounce: the stable level must hold for DEB_CYC cycles.
    always_comb
    begin
        lvl_next = lvl_reg;
        prs_next = 1'b0;
        cnt_next = cnt_reg;
        if (s2_reg == lvl_reg)
            cnt_next = '0;
        else if (cnt_reg == 21'(DEB_CYC - 1))
        begin
            cnt_next = '0;
            lvl_next = s2_reg;
            prs_next = s2_reg;
        end
        else
            cnt_next = cnt_reg + 21'h1;
    end

    // The first flop only feeds the second.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            lvl_reg <= 1'b0;
            prs_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            lvl_reg <= lvl_next;
            prs_reg <= prs_next;
            cnt_reg <= cnt_next;
        end
    end

    assign level = lvl_reg;
    assign press = prs_reg;
endmodule

/* fmsl_tick.sv */
// One-second tick generator with a brief-flash window.
`timescale 1ns/10ps
module fmsl_tick
    import fmsl_pkg::*;
#(
    parameter int unsigned TICK_CYC = FMSL_TICK_CYC,
    parameter int unsigned FLASH_CYC = FMSL_FLASH_CYC
)(
    input wire logic clk,
    input wire logic nrst,
    output logic tick,
    output logic flash,
    output logic [31:0] ms_cnt
);
    logic [31:0] cnt_reg, cnt_next;
    logic tick_reg, tick_next;

    // Free-running count that wraps once a second.
    always_comb
    begin
        tick_next = (cnt_reg == TICK_CYC - 1);
        cnt_next = tick_next ? 32'h0 : cnt_reg + 32'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
    assign flash = (cnt_reg < FLASH_CYC);
    assign ms_cnt = cnt_reg;
endmodule

/* fmsl_led_driver.sv */
// Front-panel lamp driver of the flame monitor, with AXI4-Lite registers.
`timescale 1ns/10ps
module fmsl_led_driver
    import fmsl_pkg::*;
#(
    parameter int unsigned TICK_CYC = FMSL_TICK_CYC,
    parameter int unsigned FLASH_CYC = FMSL_FLASH_CYC,
    parameter int unsigned DEB_CYC = FMSL_DEB_CYC,
    parameter int unsigned NCH = FMSL_NCH
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NCH-1:0] relay_on,
    input wire logic [NCH*FMSL_STR_W-1:0] strength,
    input wire logic [NCH-1:0] ir_en,
    input wire logic [NCH-1:0] uv_en,
    input wire logic [NCH-1:0] head_hot,
    input wire logic lockout_evt,
    input wire logic comm_ok,
    input wire logic self_ok,
    input wire logic reset_btn,
    output logic [NCH-1:0] flame_on_led,
    output logic [2*NCH-1:0] signal_led,
    output logic [1:0] status_led,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic tick, flash, btn_press;
    logic [31:0] ms_cnt;
    logic lock_reg, lock_next;
    logic phase_reg, phase_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
    logic [7:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0] ws_reg, ws_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic r_reg, r_next;
    logic [31:0] rd_reg, rd_next;
    logic [NCH-1:0] fon_reg, fon_next;
    logic [2*NCH-1:0] sig_reg, sig_next;
    logic [1:0] st_reg, st_next;
    fmsl_hb_e hb;
    logic [NCH-1:0] blink;
    logic ena;
    logic phase;

    // Shared one-second time base.
    fmsl_tick #(
        .TICK_CYC(TICK_CYC),
        .FLASH_CYC(FLASH_CYC)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .flash(flash),
        .ms_cnt(ms_cnt)
    );

    // Reset button synchronised and debounced to one press pulse.
    fmsl_sync #(
        .DEB_CYC(DEB_CYC)
    ) u_btn (
        .clk(clk),
        .nrst(nrst),
        .pin(reset_btn),
        .level(),
        .press(btn_press)
    );

    // Flash period in cycles for a flame strength: halves per step.
    // It is four TICK_CYC shifted right by the step, so it scales with the shared time base.
    function automatic logic [31:0] sig_period(input logic [11:0] s);
        logic [2:0] step;
        step = s[11:9] > 3'(FMSL_SIG_STEPS - 1) ? 3'(FMSL_SIG_STEPS - 1)
            : s[11:9];
        sig_period = 32'(FMSL_SIG_SLOW_MS / FMSL_TICK_MS * TICK_CYC) >> step;
    endfunction

    // Colour from sensor configuration.
    function automatic logic [1:0] sig_colour(input logic ir, input logic uv);
        if (ir && uv)
            sig_colour = FMSL_COL_ORG;
        else if (ir)
            sig_colour = FMSL_COL_RED;
        else if (uv)
            sig_colour = FMSL_COL_GRN;
        else
            sig_colour = FMSL_COL_OFF;
    endfunction

    // Per-channel flash rate generator.
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic [31:0] pc_reg, pc_next;
            logic [31:0] per;
            always_comb
            begin
                per = sig_period(strength[g*FMSL_STR_W +: FMSL_STR_W]);
                pc_next = (pc_reg >= per - 32'h1) ? 32'h0 : pc_reg + 32'h1;
            end
            always_ff @(posedge clk)
            begin
                if (!nrst)
                    pc_reg <= 32'h0;
                else
                    pc_reg <= pc_next;
            end
            // Lamp lit for the first eighth of each period, if strength is non-zero.
            assign blink[g] = (strength[g*FMSL_STR_W +: FMSL_STR_W] != 12'h0)
                && (pc_reg < (per >> 3));
        end
    endgenerate

    assign ena = ctrl_reg[FMSL_CTRL_ENA];

    // Phase as it stands from the tick on, so no flash straddles a change.
    assign phase = phase_reg ^ tick;

    // Heartbeat mode choice; lockout outranks everything.
    always_comb
    begin
        if (lock_reg)
            hb = FMSL_HB_LOCK;
        else if (!comm_ok)
            hb = FMSL_HB_COMM;
        else if (!self_ok || !ena)
            hb = FMSL_HB_FAIL;
        else if (|head_hot)
            hb = FMSL_HB_HOT;
        else
            hb = FMSL_HB_NORMAL;
    end

    // Lockout latch and one-second colour phase.
    always_comb
    begin
        lock_next = lock_reg;
        if (lockout_evt || ctrl_reg[FMSL_CTRL_FORCE_LK])
            lock_next = 1'b1; // Set wins over a same-cycle press.
        else if (btn_press)
            lock_next = 1'b0;
        phase_next = tick ? ~phase_reg : phase_reg;
    end

    // Lamp pattern generation.
    always_comb
    begin
        fon_next = lock_reg ? '0 : relay_on;
        for (int i = 0; i < NCH; i++)
            sig_next[2*i +: 2] = blink[i] ? sig_colour(ir_en[i], uv_en[i])
                : FMSL_COL_OFF;
        st_next = FMSL_COL_RED;
        unique case (hb)
            FMSL_HB_LOCK:
                st_next = phase ? FMSL_COL_GRN : FMSL_COL_RED;
            FMSL_HB_NORMAL:
                st_next = flash ? FMSL_COL_GRN : FMSL_COL_OFF;
            FMSL_HB_HOT:
                st_next = !flash ? FMSL_COL_OFF
                    : (phase ? FMSL_COL_GRN : FMSL_COL_RED);
            FMSL_HB_COMM:
                st_next = flash ? FMSL_COL_OFF : FMSL_COL_RED;
            FMSL_HB_FAIL:
                st_next = FMSL_COL_RED; // Steady red reads as failure.
        endcase
        if (lock_reg)
            for (int i = 0; i < NCH; i++)
                sig_next[2*i +: 2] = phase ? FMSL_COL_RED
                    : FMSL_COL_GRN;
    end

    // AXI4-Lite write and read channels.
    always_comb
    begin
        aw_next = aw_reg;
        awa_next = awa_reg;
        w_next = w_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        b_next = b_reg;
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        r_next = r_reg;
        rd_next = rd_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (aw_reg && w_reg && !b_reg)
        begin
            aw_next = 1'b0;
            w_next = 1'b0;
            b_next = 1'b1;
            bresp_next = FMSL_RESP_OK;
            if (awa_reg[7:2] == FMSL_ADDR_CTRL[7:2])
            begin
                for (int i = 0; i < 4; i++)
                    if (ws_reg[i])
                        ctrl_next[8*i +: 8] = wd_reg[8*i +: 8];
            end
            else if (awa_reg[7:2] != FMSL_ADDR_STAT[7:2]
                && awa_reg[7:2] != FMSL_ADDR_LAMP[7:2])
                bresp_next = FMSL_RESP_SLVERR;
        end
        if (b_reg && s_axi_bready)
            b_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            r_next = 1'b1;
            rresp_next = FMSL_RESP_OK;
            unique case (s_axi_araddr[7:2])
                FMSL_ADDR_CTRL[7:2]: rd_next = ctrl_reg;
                FMSL_ADDR_STAT[7:2]:
                    rd_next = {25'h0, 3'(hb), 3'h0, lock_reg};
                FMSL_ADDR_LAMP[7:2]:
                    rd_next = {16'h0, 2'h0, st_reg, 2'h0, sig_reg, 1'b0,
                        fon_reg};
                default:
                begin
                    rd_next = 32'h0;
                    rresp_next = FMSL_RESP_SLVERR;
                end
            endcase
        end
        else if (r_reg && s_axi_rready)
            r_next = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            lock_reg <= 1'b0;
            phase_reg <= 1'b0;
            fon_reg <= '0;
            sig_reg <= '0;
            st_reg <= FMSL_COL_OFF;
            ctrl_reg <= FMSL_CTRL_RST;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            b_reg <= 1'b0;
            awa_reg <= 8'h0;
            wd_reg <= 32'h0;
            ws_reg <= 4'h0;
            bresp_reg <= FMSL_RESP_OK;
            r_reg <= 1'b0;
            rd_reg <= 32'h0;
            rresp_reg <= FMSL_RESP_OK;
        end
        else
        begin
            lock_reg <= lock_next;
            phase_reg <= phase_next;
            fon_reg <= fon_next;
            sig_reg <= sig_next;
            st_reg <= st_next;
            ctrl_reg <= ctrl_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            b_reg <= b_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            bresp_reg <= bresp_next;
            r_reg <= r_next;
            rd_reg <= rd_next;
            rresp_reg <= rresp_next;
        end
    end

    // Bus handshakes and lamp outputs.
    assign s_axi_awready = !aw_reg && !b_reg;
    assign s_axi_wready = !w_reg && !b_reg;
    assign s_axi_bvalid = b_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !r_reg;
    assign s_axi_rvalid = r_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rresp_reg;
    assign flame_on_led = fon_reg;
    assign signal_led = sig_reg;
    assign status_led = st_reg;

    // Checks on lamp behaviour.
    sequence s_lock_set;
        lockout_evt;
    endsequence

    AST_LOCK_SET: assert property (@(posedge clk) disable iff (!nrst)
        s_lock_set |=> lock_reg)
        else $error("Lockout not latched.");
    AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        lock_reg && !btn_press |=> lock_reg)
        else $error("Lockout dropped without a press.");
    AST_FON_DARK: assert property (@(posedge clk) disable iff (!nrst)
        lock_reg |=> flame_on_led == '0)
        else $error("Flame-on lamp lit in lockout.");
    AST_FON_RELAY: assert property (@(posedge clk) disable iff (!nrst)
        !lock_reg && !lock_next |=> flame_on_led == $past(relay_on))
        else $error("Flame-on lamp does not follow relay.");
    AST_LOCK_ALT: assert property (@(posedge clk) disable iff (!nrst)
        lock_reg && lock_next |=> status_led == FMSL_COL_RED
            || status_led == FMSL_COL_GRN)
        else $error("Lockout status not red or green.");
    AST_NORMAL: assert property (@(posedge clk) disable iff (!nrst)
        hb == FMSL_HB_NORMAL && !flash |=> status_led == FMSL_COL_OFF)
        else $error("Normal heartbeat lit outside flash.");
    AST_COMM: assert property (@(posedge clk) disable iff (!nrst)
        hb == FMSL_HB_COMM && !flash |=> status_led == FMSL_COL_RED)
        else $error("Comm heartbeat not red.");
    AST_HOT: assert property (@(posedge clk) disable iff (!nrst)
        hb == FMSL_HB_HOT && flash |=> status_led != FMSL_COL_OFF)
        else $error("Hot heartbeat missing flash.");
    AST_FAIL: assert property (@(posedge clk) disable iff (!nrst)
        hb == FMSL_HB_FAIL |=> status_led == FMSL_COL_RED)
        else $error("Failure not steady.");
    AST_TICK: assert property (@(posedge clk) disable iff (!nrst)
        tick |=> !tick)
        else $error("Tick longer than one cycle.");
endmodule

/* fmsl_operator.sv */
// Operator model that works the front-panel reset button.
`timescale 1ns/10ps
module fmsl_operator
    import fmsl_pkg::*;
#(
    parameter int unsigned HOLD_CYC = 20
)(
    input wire logic clk,
    input wire logic press_req,
    output logic reset_btn
);
    int unsigned hold_cnt = 0;

    // A request holds the button down well past the debounce time.
    always @(posedge clk)
    begin
        if (press_req && hold_cnt == 0)
            hold_cnt <= HOLD_CYC;
        else if (hold_cnt != 0)
            hold_cnt <= hold_cnt - 1;
    end

    // The released button rests low, as its pull-down leaves it.
    assign reset_btn = (hold_cnt != 0);
endmodule

/* fmsl_led_driver_tb.sv */
// Self-checking bench of the front-panel lamp driver.
`timescale 1ns/10ps
module fmsl_led_driver_tb;
    import fmsl_pkg::*;
    localparam int TICK = 100;
    localparam int LIMIT = 6000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] relay_on = 3'h0, ir_en = 3'h1, uv_en = 3'h0, head_hot = 3'h0;
    logic [35:0] strength = 36'h0;
    logic lockout_evt = 1'b0, comm_ok = 1'b1, self_ok = 1'b1, press_req = 1'b0;
    logic reset_btn;
    logic [2:0] flame_on_led;
    logic [5:0] signal_led;
    logic [1:0] status_led;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] seed = 32'h161d3;
    int fail_count = 0, checks = 0, cyc = 0, fo_lit;
    int st_cnt [4], sig_bad [3], sig_lit [3], sig_edge [3];

    fmsl_led_driver #(.TICK_CYC(TICK), .FLASH_CYC(10), .DEB_CYC(4), .NCH(3))
    u_fmsl_led_driver (.clk(clk), .nrst(nrst), .relay_on(relay_on),
        .strength(strength), .ir_en(ir_en), .uv_en(uv_en),
        .head_hot(head_hot), .lockout_evt(lockout_evt), .comm_ok(comm_ok),
        .self_ok(self_ok), .reset_btn(reset_btn),
        .flame_on_led(flame_on_led), .signal_led(signal_led),
        .status_led(status_led), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    fmsl_operator u_fmsl_operator (.clk(clk), .press_req(press_req),
        .reset_btn(reset_btn));

    // Free-running 50 MHz clock.
    always #10 clk = ~clk;

    // Cuts a hung run short and reports it as a mismatch.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            fail_count++;
            end_of_test();
        end
    end

    // Random source, started at 90579.
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Colour that a channel's sensor setup should give its signal lamp.
    function automatic logic [1:0] exp_col(input logic ir, input logic uv);
        return (ir && uv) ? FMSL_COL_ORG : ir ? FMSL_COL_RED :
            uv ? FMSL_COL_GRN : FMSL_COL_OFF;
    endfunction

    task automatic check_bits(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_count(input string nm, input int e, input int g);
        checks++;
        if (g != e)
        begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Compares a window's status lamp colour counts.
    task automatic chk_st(input int r, input int g, input int o);
        check_count("status red", r, st_cnt[FMSL_COL_RED]);
        check_count("status green", g, st_cnt[FMSL_COL_GRN]);
        check_count("status dark", o, st_cnt[FMSL_COL_OFF]);
    endtask

    // Watches the lamps for n cycles, sampling between edges.
    task automatic watch(input int n);
        logic [5:0] prev;
        prev = signal_led;
        st_cnt = '{0, 0, 0, 0};
        sig_bad = '{0, 0, 0};
        sig_lit = '{0, 0, 0};
        sig_edge = '{0, 0, 0};
        fo_lit = 0;
        repeat (n)
        begin
            @(negedge clk);
            st_cnt[status_led]++;
            if (flame_on_led != 3'h0)
                fo_lit++;
            for (int c = 0; c < 3; c++)
            begin
                if (signal_led[2*c+:2] != 2'h0)
                begin
                    sig_lit[c]++;
                    if (signal_led[2*c+:2] != exp_col(ir_en[c], uv_en[c]))
                        sig_bad[c]++;
                    if (prev[2*c+:2] == 2'h0)
                        sig_edge[c]++;
                end
            end
            prev = signal_led;
        end
        @(posedge clk);
    endtask

    // Register write; ready is sampled between edges, then taken at the edge.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic aw_hit, w_hit, done;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(negedge clk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw_hit)
                s_axi_awvalid <= 1'b0;
            if (w_hit)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    // Register read with the same sampling scheme.
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ar_hit, done;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(negedge clk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar_hit)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic press();
        press_req <= 1'b1;
        @(posedge clk);
        press_req <= 1'b0;
        repeat (40) @(posedge clk);
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence: registers, channel lamps, heartbeats, lockout.
    initial
    begin
        logic [31:0] rd, rnd;
        logic [1:0] rs;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check_count("lamps", 7, $bits(flame_on_led) + $bits(signal_led) / 2
            + $bits(status_led) / 2);
        axi_read(FMSL_ADDR_CTRL, rd, rs);
        check_bits("ctrl reset", FMSL_CTRL_RST, rd);
        axi_write(8'h40, 32'h3, rs);
        check_bits("bad write", {30'h0, FMSL_RESP_SLVERR}, {30'h0, rs});
        axi_read(8'h44, rd, rs);
        check_bits("bad read", {30'h0, FMSL_RESP_SLVERR}, {rd[29:0], rs});
        for (int i = 0; i < 6; i++)
        begin
            rnd = xorshift();
            relay_on <= rnd[2:0];
            ir_en <= (i < 3) ? {3{i != 1}} : rnd[5:3] | ~rnd[8:6];
            uv_en <= (i < 3) ? {3{i != 0}} : rnd[8:6];
            strength <= {3'h7, rnd[8:0], 3'h6, rnd[17:9], 3'h5, rnd[26:18]};
            repeat (3) @(posedge clk);
            check_bits("flame on", {29'h0, relay_on}, {29'h0, flame_on_led});
            watch(TICK);
            for (int c = 0; c < 3; c++)
            begin
                check_count("wrong colour", 0, sig_bad[c]);
                check_count("signal lit", 1, int'(sig_lit[c] > 0));
            end
        end
        strength <= {12'h000, 12'he00, 12'h001};
        watch(4 * TICK);
        check_count("slow flashes", 1, int'(sig_edge[0] <= 2));
        check_count("slow lit", 1, int'(sig_lit[0] > 0));
        check_count("fast flashes", 1, int'(sig_edge[1] >= 16));
        check_count("zero strength", 0, sig_lit[2]);
        watch(TICK);
        chk_st(0, 10, 90);
        head_hot <= 3'h2;
        repeat (TICK) @(posedge clk);
        watch(2 * TICK);
        chk_st(10, 10, 180);
        check_bits("hot flame on", {29'h0, relay_on}, {29'h0, flame_on_led});
        head_hot <= 3'h0;
        self_ok <= 1'b0;
        repeat (TICK) @(posedge clk);
        watch(TICK);
        chk_st(TICK, 0, 0);
        self_ok <= 1'b1;
        axi_write(FMSL_ADDR_CTRL, 32'h0, rs);
        repeat (TICK) @(posedge clk);
        watch(TICK);
        chk_st(TICK, 0, 0);
        axi_write(FMSL_ADDR_CTRL, 32'h1, rs);
        comm_ok <= 1'b0;
        repeat (TICK) @(posedge clk);
        watch(TICK);
        chk_st(90, 0, 10);
        relay_on <= 3'h7;
        lockout_evt <= 1'b1;
        @(posedge clk);
        lockout_evt <= 1'b0;
        repeat (3) @(posedge clk);
        watch(2 * TICK);
        chk_st(TICK, TICK, 0);
        check_count("dark flame on", 0, fo_lit);
        axi_read(FMSL_ADDR_STAT, rd, rs);
        check_bits("latched", 32'h41, rd & 32'h71);
        comm_ok <= 1'b1;
        press();
        axi_read(FMSL_ADDR_STAT, rd, rs);
        check_bits("cleared", 32'h0, rd & 32'h1);
        check_bits("flame back", 32'h7, {29'h0, flame_on_led});
        axi_write(FMSL_ADDR_CTRL, 32'h3, rs);
        press();
        check_bits("forced dark", 32'h0, {29'h0, flame_on_led});
        axi_read(FMSL_ADDR_STAT, rd, rs);
        check_bits("press refused", 32'h1, rd & 32'h1);
        axi_write(FMSL_ADDR_CTRL, 32'h1, rs);
        press();
        axi_read(FMSL_ADDR_STAT, rd, rs);
        check_bits("force cleared", 32'h0, rd & 32'h1);
        end_of_test();
    end
endmodule
